// ---- tb/gdfm_ctrl_model.sv ----
// gdfm_ctrl_model: behavioural motor controller that drives the enable pin.
// assumes its tasks are called from one bench process at a time.
`timescale 1ns/10ps
module gdfm_ctrl_model
#(
  parameter int WAKE_CYC = 4
)
(
  // clock
  input  wire logic clk,
  // controller pins
  output logic      enablePin,
  input  wire logic faultOutN
);
  initial enablePin = 1'b0;

  // raise enable, then keep quiet until the device is ready
  task automatic wake();
    @(posedge clk);
    enablePin <= 1'b1;
    repeat (WAKE_CYC) @(posedge clk);
  endtask

  // high-low-high; a low longer than the reset window asks for sleep instead
  task automatic lowPulse(input int lowCyc);
    @(posedge clk);
    enablePin <= 1'b0;
    repeat (lowCyc) @(posedge clk);
    enablePin <= 1'b1;
    repeat (WAKE_CYC) @(posedge clk);
  endtask
endmodule

// ---- tb/testbench.sv ----
// testbench: self-checking bench of the gate-driver fault and mode manager.
// assumes short retry and reset windows; the controller model owns the enable pin.
`timescale 1ns/10ps
module testbench
  import gdfm_pkg::*;
;
  localparam int RETRY = 50;
  localparam int RSTW  = 20;

  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        enablePin;
  logic        faultOutN;
  logic        err;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] w;
  gdfm_sense_s sense;
  gdfm_power_s power;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cycles = 0;

  gdfm_fault_mgr #(.RETRY_CYCLES(RETRY), .RST_CYCLES(RSTW)) dut_u (
    .clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enablePin(enablePin), .faultOutN(faultOutN), .sense(sense), .power(power));

  gdfm_ctrl_model ctrl_u (.clk(clk), .enablePin(enablePin), .faultOutN(faultOutN));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // hang guard, well above the length of the sequence
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // one apb transfer; read data and error are taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // change the monitors and let latched paths settle
  task automatic drive(input gdfm_sense_s s);
    @(posedge clk);
    sense <= s;
    step(4);
  endtask

  function automatic gdfm_power_s opPower();
    gdfm_power_s p;
    p = 7'h3F;
    p.gateDriveEnable = 1'b1;
    p.passivePulldown = 1'b0;
    return p;
  endfunction

  function automatic logic [31:0] ctrlRead(input logic [31:0] wd);
    return {25'h0, wd[6:1], 1'b0};
  endfunction

  task automatic pinGate(input logic pin, input logic gate, input string msg);
    chk(faultOutN, pin, msg);
    chk(power.gateDriveEnable, gate, msg);
  endtask

  initial
  begin
    rst_b   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    sense   = '0;
    void'($urandom(84));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    step(2);
    chk(power, POWER_RESET, "sleep power");
    chk(faultOutN, 1'b1, "sleep pin");
    apb(1'b1, CTRL_OFS, 32'h40);
    chk(err, 1'b1, "asleep write");
    ctrl_u.wake();
    step(1);
    chk(power, opPower(), "operating power");
    for (int i = 0; i < 8; i++)
    begin
      w = $urandom() & 32'h7E;
      apb(1'b1, CTRL_OFS, w);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, ctrlRead(w), "ctrl readback");
    end
    apb(1'b0, 8'h08, 32'h0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, STAT_OFS, 32'hFF);
    chk(err, 1'b1, "status write");
    // thermal warning, unreported then reported
    apb(1'b1, CTRL_OFS, 32'h0);
    drive(9'h100);
    pinGate(1'b1, 1'b1, "warn quiet");
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rd[5], 1'b1, "warn status");
    apb(1'b1, CTRL_OFS, 32'h40);
    step(3);
    pinGate(1'b0, 1'b1, "warn reported");
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rd[0], 1'b1, "warn global");
    drive(9'h000);
    apb(1'b0, STAT_OFS, 32'h0);
    chk({faultOutN, rd[5]}, 2'b10, "warn gone");
    // overheating with every disable set
    apb(1'b1, CTRL_OFS, 32'h3E);
    drive(9'h080);
    pinGate(1'b0, 1'b0, "overheat");
    chk(power.chargePumpEnable, 1'b0, "pump off");
    apb(1'b0, STAT_OFS, 32'h0);
    chk({rd[4], rd[0]}, 2'b11, "overheat status");
    drive(9'h000);
    pinGate(1'b1, 1'b1, "overheat gone");
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rd[4], 1'b1, "overheat flag kept");
    apb(1'b1, CTRL_OFS, 32'h3F);
    step(2);
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rd[4], 1'b0, "overheat flag cleared");
    // every overcurrent response mode
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, CTRL_OFS, 32'(m << 1));
      // shunt sense in the even modes, drain-source sense in the odd ones
      drive((m % 2 == 1) ? 9'h002 : 9'h001);
      pinGate(m == 3, m >= 2, "overcurrent");
      drive(9'h000);
      pinGate(m == 3, m >= 2, "overcurrent held");
      apb(1'b0, STAT_OFS, 32'h0);
      chk({rd[7], rd[1]}, (m == 3) ? 2'b00 : (m % 2 == 1) ? 2'b01 : 2'b10, "overcurrent status");
      if (m == 1)
        step(RETRY + 5);
      else
        apb(1'b1, CTRL_OFS, 32'((m << 1) | 1));
      step(3);
      pinGate(1'b1, 1'b1, "overcurrent recovered");
    end
    apb(1'b1, CTRL_OFS, 32'h08);
    drive(9'h001);
    pinGate(1'b1, 1'b1, "shunt disabled");
    drive(9'h000);
    // stuck gate, disabled then latched and cleared by a short pulse
    apb(1'b1, CTRL_OFS, 32'h10);
    drive(9'h004);
    pinGate(1'b1, 1'b1, "stuck disabled");
    drive(9'h000);
    apb(1'b1, CTRL_OFS, 32'h40);
    drive(9'h004);
    drive(9'h000);
    pinGate(1'b0, 1'b0, "stuck latched");
    ctrl_u.lowPulse(RSTW / 2);
    step(1);
    pinGate(1'b1, 1'b1, "pulse cleared");
    chk(power, opPower(), "pulse keeps power");
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h40, "pulse keeps ctrl");
    // undervoltages recover by themselves
    apb(1'b1, CTRL_OFS, 32'h0);
    drive(9'h010);
    pinGate(1'b0, 1'b0, "pump uv");
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rd[6], 1'b1, "gate uv status");
    drive(9'h008);
    pinGate(1'b0, 1'b0, "lowside uv");
    drive(9'h000);
    pinGate(1'b1, 1'b1, "gate uv gone");
    apb(1'b1, CTRL_OFS, 32'h20);
    drive(9'h010);
    pinGate(1'b1, 1'b1, "gate uv disabled");
    drive(9'h020);
    pinGate(1'b0, 1'b0, "drain uv");
    drive(9'h040);
    pinGate(1'b0, 1'b0, "motor uv");
    chk(power.passivePulldown, 1'b1, "lockout pulldown");
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rd[3], 1'b1, "lockout status");
    drive(9'h000);
    pinGate(1'b1, 1'b1, "supply back");
    // a long low is a sleep request and restores defaults
    ctrl_u.lowPulse(RSTW + 5);
    step(1);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h0, "sleep defaults");
    summarize();
  end
endmodule

// ---- verilog/gdfm_enable_pulse.sv ----
// gdfm_enable_pulse: measures low periods of the enable pin and classifies them.
// assumes enablePin is synchronous to clk; a short low gives a reset pulse, a long low a sleep request.
`timescale 1ns/10ps
module gdfm_enable_pulse
  import gdfm_pkg::*;
#(
  parameter int WINDOW_CYC = RST_WINDOW_CYC
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // pin
  input  wire logic enablePin,
  // classification
  output logic      resetPulse,
  output logic      sleepReq
);

  localparam int             CW  = $clog2(WINDOW_CYC + 1);
  localparam logic [CW-1:0]  WIN = CW'(WINDOW_CYC);
  localparam logic [CW-1:0]  ONE = CW'(1);

  logic [CW-1:0] lowCnt_q;
  logic [CW-1:0] lowCnt_d;
  logic          enPrev_q;
  logic          sleepReq_q;
  logic          sleepReq_d;
  logic          resetPulse_q;
  logic          resetPulse_d;

  always_comb
  begin
    lowCnt_d     = '0;
    if (!enablePin)
    begin
      lowCnt_d = (lowCnt_q == WIN) ? lowCnt_q : lowCnt_q + ONE;
    end
    // low beyond the window means a full shutdown request
    sleepReq_d   = !enablePin && (sleepReq_q || lowCnt_q == WIN);
    resetPulse_d = enablePin && !enPrev_q && !sleepReq_q;
  end

  // sleep request comes out of reset set, so a power-up edge is never taken as a reset pulse
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lowCnt_q     <= '0;
      enPrev_q     <= 1'b0;
      sleepReq_q   <= 1'b1;
      resetPulse_q <= 1'b0;
    end
    else
    begin
      lowCnt_q     <= lowCnt_d;
      enPrev_q     <= enablePin;
      sleepReq_q   <= sleepReq_d;
      resetPulse_q <= resetPulse_d;
    end
  end

  assign resetPulse = resetPulse_q;
  assign sleepReq   = sleepReq_q;

endmodule

// ---- verilog/gdfm_fault_mgr.sv ----
// gdfm_fault_mgr: fault supervision, fault pin and sleep/operating sequencing of a three-phase gate driver.
// assumes monitor inputs and the enable pin are synchronous to clk; registers sit on an APB slave port.
// Functional notes
// - thermal warning sets status, no action
// - warning status clears when temperature falls
// - warning reported on fault pin if enabled
// - overtemperature stops gates, pump; fault pin low
// - gates resume; overheat flag stays until cleared
// - thermal shutdown cannot be disabled
// - enable low means sleep, everything off
// - entering sleep restores register defaults
// - sleep or lockout: passive gate pulldowns
// - enable high, supply good: operating mode
// - latched fault holds partial shutdown
// - clear bit or enable pulse leaves it
// - long enable low goes to sleep
// - reset pulse clears faults only
// - latched overcurrent: off until cleared
// - retry overcurrent: resumes after retry time
// - report-only keeps switching; disabled ignores
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module gdfm_fault_mgr
  import gdfm_pkg::*;
#(
  parameter int RETRY_CYCLES = RETRY_CYC,
  parameter int RST_CYCLES   = RST_WINDOW_CYC
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // controller pins
  input  wire logic        enablePin,
  output logic             faultOutN,
  // analog side
  input  wire gdfm_sense_s sense,
  output gdfm_power_s      power
);

  gdfm_mode_e  mode_q;
  gdfm_mode_e  mode_d;
  gdfm_ctrl_s  ctrl_q;
  gdfm_ctrl_s  ctrl_d;
  gdfm_power_s power_q;
  gdfm_power_s power_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        faultOutN_q;
  logic        faultOutN_d;
  logic        globalFault_q;
  logic        tsdLatch_q;
  logic        tsdLatch_d;
  logic        dsLatch_q;
  logic        dsLatch_d;
  logic        shLatch_q;
  logic        shLatch_d;
  logic        gdfLatch_q;
  logic        gdfLatch_d;
  logic        resetPulse;
  logic        sleepReq;
  logic        retryBusy;
  logic        retryDone;
  logic        awake;
  logic        clearAll;
  logic        ocRetry;
  logic        ocHold;
  logic        dsEvt;
  logic        shEvt;
  logic        gdfEvt;
  logic        gsuvEvt;
  logic        gatesOff;
  logic        faultAny;
  logic        apbAccess;
  logic        apbWrite;
  logic        hitCtrl;
  logic        hitStat;
  gdfm_ocm_e   ocm;
  gdfm_stat_s  stat;

  gdfm_enable_pulse #(
    .WINDOW_CYC (RST_CYCLES)
  ) uEnable (
    .clk        (clk),
    .rst_b      (rst_b),
    .enablePin  (enablePin),
    .resetPulse (resetPulse),
    .sleepReq   (sleepReq)
  );

  gdfm_retry_timer #(
    .CYCLES (RETRY_CYCLES)
  ) uRetry (
    .clk   (clk),
    .rst_b (rst_b),
    .start (ocRetry && (dsEvt || shEvt)),
    .abort (!awake || ocm != OCM_RETRY),
    .busy  (retryBusy),
    .done  (retryDone)
  );

  // mode sequencing
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      MODE_SLEEP:
      begin
        if (enablePin)
        begin
          mode_d = sense.motorSupplyUndervoltage ? MODE_LOCKOUT : MODE_OPER;
        end
      end
      MODE_LOCKOUT:
      begin
        if (sleepReq)
        begin
          mode_d = MODE_SLEEP;
        end
        else if (!sense.motorSupplyUndervoltage)
        begin
          mode_d = MODE_OPER;
        end
      end
      MODE_OPER:
      begin
        if (sleepReq)
        begin
          mode_d = MODE_SLEEP;
        end
        else if (sense.motorSupplyUndervoltage)
        begin
          mode_d = MODE_LOCKOUT;
        end
      end
      default:
      begin
        mode_d = MODE_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_q <= MODE_SLEEP;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  assign awake     = (mode_q != MODE_SLEEP);
  assign ocm       = gdfm_ocm_e'(ctrl_q.overcurrentResponseMode);
  // a short enable low clears faults and nothing else: registers and supplies are not touched
  assign clearAll  = ctrl_q.clearFaultBit || resetPulse;
  assign ocRetry   = (ocm == OCM_RETRY) && !retryBusy;
  assign ocHold    = (dsLatch_q || shLatch_q) && (ocm == OCM_LATCH || ocm == OCM_RETRY);
  assign dsEvt     = awake && sense.drainSourceOvercurrent && ocm != OCM_OFF;
  assign shEvt     = awake && sense.shuntOvercurrent && ocm != OCM_OFF && !ctrl_q.shuntOvercurrentDisable;
  assign gdfEvt    = awake && sense.gateStuckFault && !ctrl_q.gateStuckFaultDisable;
  assign gsuvEvt   = (sense.pumpUndervoltage || sense.lowsideRegUndervoltage) && !ctrl_q.gateSupplyUvDisable;

  // fault latches; a live condition re-sets its latch, so the set wins over any clear
  always_comb
  begin
    tsdLatch_d = awake && (sense.thermalShutdown || (tsdLatch_q && !clearAll));
    gdfLatch_d = gdfEvt || (awake && gdfLatch_q && !clearAll);
    if (ocm == OCM_RETRY)
    begin
      dsLatch_d = dsEvt || (awake && dsLatch_q && !retryDone);
      shLatch_d = shEvt || (awake && shLatch_q && !retryDone);
    end
    else
    begin
      dsLatch_d = dsEvt || (awake && dsLatch_q && !clearAll);
      shLatch_d = shEvt || (awake && shLatch_q && !clearAll);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tsdLatch_q <= 1'b0;
      dsLatch_q  <= 1'b0;
      shLatch_q  <= 1'b0;
      gdfLatch_q <= 1'b0;
    end
    else
    begin
      tsdLatch_q <= tsdLatch_d;
      dsLatch_q  <= dsLatch_d;
      shLatch_q  <= shLatch_d;
      gdfLatch_q <= gdfLatch_d;
    end
  end

  // gate, fault pin and supply control
  assign gatesOff = sense.thermalShutdown
                 || sense.motorSupplyUndervoltage || sense.drainSenseUndervoltage
                 || gsuvEvt
                 || ocHold || gdfLatch_q;
  assign faultAny = awake && (gatesOff || dsLatch_q || shLatch_q
                 || (sense.thermalWarning && ctrl_q.warnReportEnable));

  always_comb
  begin
    faultOutN_d              = !faultAny;
    power_d.gateDriveEnable  = (mode_q == MODE_OPER) && !gatesOff;
    power_d.passivePulldown  = (mode_q != MODE_OPER);
    power_d.chargePumpEnable = awake && !sense.thermalShutdown;
    power_d.lowsideRegEnable = awake;
    power_d.digitalRegEnable = awake;
    power_d.senseAmpEnable   = awake;
    power_d.serialEnable     = awake;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      faultOutN_q   <= 1'b1;
      globalFault_q <= 1'b0;
      power_q       <= POWER_RESET;
    end
    else
    begin
      faultOutN_q   <= faultOutN_d;
      globalFault_q <= faultAny;
      power_q       <= power_d;
    end
  end

  // apb slave; zero wait states, serial side refuses every access while asleep
  assign apbAccess = psel && penable;
  assign hitCtrl   = (paddr == CTRL_OFS);
  assign hitStat   = (paddr == STAT_OFS);
  assign apbWrite  = apbAccess && pwrite && awake && hitCtrl;
  assign pready    = 1'b1;
  assign pslverr   = apbAccess && (!awake || !(hitCtrl || (hitStat && !pwrite)));

  always_comb
  begin
    stat.shuntOvercurrent       = shLatch_q;
    stat.gateSupplyUndervoltage = awake && gsuvEvt;
    stat.thermalWarning         = awake && sense.thermalWarning;
    stat.overheatLatchedFlag    = tsdLatch_q;
    stat.supplyLockout          = awake && sense.motorSupplyUndervoltage;
    stat.gateStuckFault         = gdfLatch_q;
    stat.drainSourceOvercurrent = dsLatch_q;
    stat.globalFault            = globalFault_q;
  end

  always_comb
  begin
    prdata_d = prdata_q;
    if (psel && !penable)
    begin
      prdata_d = '0;
      if (awake && hitCtrl)
      begin
        prdata_d[CTRL_W-1:0] = ctrl_q;
      end
      else if (awake && hitStat)
      begin
        prdata_d[STAT_W-1:0] = stat;
      end
    end
    // clear command lasts one cycle
    ctrl_d               = ctrl_q;
    ctrl_d.clearFaultBit = 1'b0;
    if (!awake)
    begin
      ctrl_d = CTRL_RESET;
    end
    else if (apbWrite)
    begin
      ctrl_d = pwdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_q   <= CTRL_RESET;
      prdata_q <= '0;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata    = prdata_q;
  assign faultOutN = faultOutN_q;
  assign power     = power_q;

  // checks
  sequence s_slept_two;
    mode_q == MODE_SLEEP ##1 mode_q == MODE_SLEEP;
  endsequence

  sequence s_clean_clear;
    awake && clearAll && ocm == OCM_LATCH && !sense.thermalShutdown && !gdfEvt && !dsEvt && !shEvt;
  endsequence

  a_tsd_response: assert property (@(posedge clk) disable iff (!rst_b)
    awake && sense.thermalShutdown |=> !faultOutN && !power.gateDriveEnable && !power.chargePumpEnable)
    else $error("thermal shutdown response missing");
  a_tsd_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    tsdLatch_q && awake && !clearAll && mode_d != MODE_SLEEP |=> tsdLatch_q)
    else $error("overheat flag dropped without clear");
  a_warn_report: assert property (@(posedge clk) disable iff (!rst_b)
    awake && sense.thermalWarning && ctrl_q.warnReportEnable |=> !faultOutN && globalFault_q)
    else $error("thermal warning not reported");
  a_sleep_outputs: assert property (@(posedge clk) disable iff (!rst_b)
    mode_q == MODE_SLEEP |=> !power.gateDriveEnable && power.passivePulldown && !power.serialEnable && faultOutN)
    else $error("sleep outputs wrong");
  a_sleep_defaults: assert property (@(posedge clk) disable iff (!rst_b)
    s_slept_two |-> ctrl_q == CTRL_RESET)
    else $error("registers not default in sleep");
  a_long_low: assert property (@(posedge clk) disable iff (!rst_b)
    sleepReq && awake |=> mode_q == MODE_SLEEP)
    else $error("long enable low did not sleep");
  a_pulse_keeps: assert property (@(posedge clk) disable iff (!rst_b)
    resetPulse && mode_q == MODE_OPER && !apbWrite && !ctrl_q.clearFaultBit |=> ctrl_q == $past(ctrl_q))
    else $error("reset pulse changed settings");
  a_clear_release: assert property (@(posedge clk) disable iff (!rst_b)
    s_clean_clear |=> !tsdLatch_q && !gdfLatch_q && !dsLatch_q && !shLatch_q)
    else $error("clear did not release latches");
  a_ocp_latched: assert property (@(posedge clk) disable iff (!rst_b)
    dsLatch_q && ocm == OCM_LATCH |=> !power.gateDriveEnable && !faultOutN)
    else $error("latched overcurrent not holding");
  a_retry_release: assert property (@(posedge clk) disable iff (!rst_b)
    retryDone && ocm == OCM_RETRY && !dsEvt && !shEvt |=> !dsLatch_q && !shLatch_q)
    else $error("retry did not release");
  a_report_runs: assert property (@(posedge clk) disable iff (!rst_b)
    mode_q == MODE_OPER && ocm == OCM_REPORT && dsEvt |=> dsLatch_q ##1 !faultOutN)
    else $error("report-only overcurrent not reported");
  a_gsuv_hiz: assert property (@(posedge clk) disable iff (!rst_b)
    awake && gsuvEvt |=> !power.gateDriveEnable && !faultOutN)
    else $error("gate supply undervoltage not handled");
  a_gdf_latch: assert property (@(posedge clk) disable iff (!rst_b)
    gdfEvt && mode_d != MODE_SLEEP |=> gdfLatch_q ##1 !faultOutN)
    else $error("gate stuck fault not latched");
  a_supply_uv: assert property (@(posedge clk) disable iff (!rst_b)
    awake && sense.drainSenseUndervoltage |=> !power.gateDriveEnable && !faultOutN)
    else $error("supply undervoltage not handled");

endmodule

// ---- verilog/gdfm_pkg.sv ----
// gdfm_pkg: shared constants, types and register layout of the gate-driver fault and mode manager.
// assumes a 50 MHz system clock and a 32-bit APB register port.
package gdfm_pkg;

  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;

  // control register, low bits of the word; bit 0 is the self-clearing clear command
  typedef struct packed {
    logic       warnReportEnable;
    logic       gateSupplyUvDisable;
    logic       gateStuckFaultDisable;
    logic       shuntOvercurrentDisable;
    logic [1:0] overcurrentResponseMode;
    logic       clearFaultBit;
  } gdfm_ctrl_s;

  localparam int         CTRL_W     = $bits(gdfm_ctrl_s);
  localparam gdfm_ctrl_s CTRL_RESET = 7'h00;

  // status register, read only
  typedef struct packed {
    logic shuntOvercurrent;
    logic gateSupplyUndervoltage;
    logic thermalWarning;
    logic overheatLatchedFlag;
    logic supplyLockout;
    logic gateStuckFault;
    logic drainSourceOvercurrent;
    logic globalFault;
  } gdfm_stat_s;

  localparam int STAT_W = $bits(gdfm_stat_s);

  // overcurrent response modes
  typedef enum logic [1:0] {
    OCM_LATCH  = 2'h0,
    OCM_RETRY  = 2'h1,
    OCM_REPORT = 2'h2,
    OCM_OFF    = 2'h3
  } gdfm_ocm_e;

  // device modes, one-hot
  typedef enum logic [2:0] {
    MODE_SLEEP   = 3'h1,
    MODE_LOCKOUT = 3'h2,
    MODE_OPER    = 3'h4
  } gdfm_mode_e;

  // analog monitor outputs, already synchronous to clk
  typedef struct packed {
    logic thermalWarning;
    logic thermalShutdown;
    logic motorSupplyUndervoltage;
    logic drainSenseUndervoltage;
    logic pumpUndervoltage;
    logic lowsideRegUndervoltage;
    logic gateStuckFault;
    logic drainSourceOvercurrent;
    logic shuntOvercurrent;
  } gdfm_sense_s;

  // enables to the analog and interface blocks
  typedef struct packed {
    logic gateDriveEnable;
    logic passivePulldown;
    logic chargePumpEnable;
    logic lowsideRegEnable;
    logic digitalRegEnable;
    logic senseAmpEnable;
    logic serialEnable;
  } gdfm_power_s;

  // only the passive gate pulldowns while in reset: gates must never be driven before the mode is known
  localparam gdfm_power_s POWER_RESET = 7'h20;

  // timing
  localparam int CLK_MHZ        = 50;
  localparam int RST_WINDOW_US  = 40;
  localparam int RST_WINDOW_CYC = RST_WINDOW_US * CLK_MHZ;
  localparam int RETRY_MS       = 4;
  localparam int RETRY_CYC      = RETRY_MS * 1000 * CLK_MHZ;

endpackage

// ---- verilog/gdfm_retry_timer.sv ----
// gdfm_retry_timer: one-shot down counter for the overcurrent automatic retry time.
// assumes start is ignored while busy; abort cancels without a done pulse.
`timescale 1ns/10ps
module gdfm_retry_timer
  import gdfm_pkg::*;
#(
  parameter int CYCLES = RETRY_CYC
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // control
  input  wire logic start,
  input  wire logic abort,
  // status
  output logic      busy,
  output logic      done
);

  localparam int            CW  = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LEN = CW'(CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          done_q;
  logic          done_d;

  always_comb
  begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (abort)
    begin
      cnt_d = '0;
    end
    else if (cnt_q != '0)
    begin
      cnt_d  = cnt_q - ONE;
      done_d = (cnt_q == ONE);
    end
    else if (start)
    begin
      cnt_d = LEN;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign busy = (cnt_q != '0);
  assign done = done_q;

endmodule
